// ===== rtl/mx_core.sv
// Execution datapath top: data memory, accumulator, flags, PC and power-down
`timescale 1ns/1ps
module mx_core
  import mx_pkg::*;
#(
  parameter int MEM_DEPTH = 160
)
(
  input  logic              mclk,
  input  logic              rst_b,
  input  logic              instr_valid,
  input  mx_instr_type      instr,
  input  logic              wake,
  output logic              instr_ready,
  output logic [DATA_W-1:0] acc_r,
  output mx_flags_type      flags_r,
  output logic [PC_W-1:0]   pc_r,
  output logic              halted_r,
  output logic              wdog_clear_r,
  output logic              done_r
);
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  mx_state_type      state_r;
  mx_instr_type      cur_r;
  logic [DATA_W-1:0] mem_rd_r;
  logic [DATA_W-1:0] result;
  logic              zero;
  logic              carry_nxt;
  logic              wake_s1_r;
  logic              wake_s2_r;
  logic              addr_ok;
  logic              zero_flag_r;
  logic              carry_flag_r;
  logic              pd_flag_r;
  logic              wdog_exp_flag_r;
  logic [1:0]        kept_flags_r;

  assign addr_ok = (cur_r.addr < ADDR_W'(MEM_DEPTH));

  // Overflow and half carry share one register, every other flag has its own; the port only bundles them
  assign flags_r = '{wdog_expired:  wdog_exp_flag_r,
                     power_down:    pd_flag_r,
                     signed_excess: kept_flags_r[1],
                     zero:          zero_flag_r,
                     aux_carry:     kept_flags_r[0],
                     carry:         carry_flag_r};

  mx_alu u_alu (
    .op        (cur_r.op),
    .acc       (acc_r),
    .mem       (mem_rd_r),
    .imm       (cur_r.imm),
    .carry_in  (flags_r.carry),
    .result    (result),
    .zero      (zero),
    .carry_out (carry_nxt)
  );

  // Wake comes from outside the clock domain
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end
    else
    begin
      wake_s1_r <= wake;
      wake_s2_r <= wake_s1_r;
    end
  end

  // Sequencer: take, read memory, execute; halt waits for wake
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_r     <= MX_RUN;
      cur_r       <= '0;
      instr_ready <= 1'b0;
    end
    else
    begin
      case (state_r)
        MX_RUN:
        begin
          instr_ready <= 1'b1;
          if (instr_valid && instr_ready)
          begin
            cur_r       <= instr;
            state_r     <= MX_MEMRD;
            instr_ready <= 1'b0;
          end
        end
        MX_MEMRD: state_r <= MX_EXEC;
        MX_EXEC:  state_r <= (cur_r.op == MX_POWER_DOWN) ? MX_HALT : MX_RUN;
        MX_HALT:
        if (wake_s2_r)
          state_r <= MX_RUN;
        default:  state_r <= MX_RUN;
      endcase
    end
  end

  // Memory read is registered so the result path has a full cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      mem_rd_r <= 8'h00;
    else if (state_r == MX_MEMRD)
      mem_rd_r <= addr_ok ? mem[cur_r.addr] : 8'h00;
  end

  // Memory holds no reset; power-down keeps its contents
  always_ff @(posedge mclk)
  begin
    if (state_r == MX_EXEC && addr_ok)
    begin
      case (cur_r.op)
        MX_ADD_ONE_MEM, MX_SUB_ONE_MEM: mem[cur_r.addr] <= result;
        MX_BCD_CORR:    mem[cur_r.addr] <= result;
        MX_COPY_A2M:    mem[cur_r.addr] <= result;
        MX_UNION_TOMEM: mem[cur_r.addr] <= result;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      acc_r <= ACC_RST;
    else if (state_r == MX_EXEC)
    begin
      case (cur_r.op)
        MX_INVERT_ACC:  acc_r <= result;
        MX_ADD_ONE_ACC, MX_SUB_ONE_ACC: acc_r <= result;
        MX_COPY_M2A:    acc_r <= result;
        MX_COPY_IMM:    acc_r <= result;
        MX_UNION_MEM, MX_UNION_IMM: acc_r <= result;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      zero_flag_r <= FLAGS_RST.zero;
    else if (state_r == MX_EXEC)
    begin
      case (cur_r.op)
        MX_INVERT_ACC, MX_ADD_ONE_MEM, MX_SUB_ONE_MEM, MX_ADD_ONE_ACC, MX_SUB_ONE_ACC,
        MX_UNION_MEM, MX_UNION_IMM, MX_UNION_TOMEM:
          zero_flag_r <= zero;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      carry_flag_r <= FLAGS_RST.carry;
    else if (state_r == MX_EXEC && cur_r.op == MX_BCD_CORR)
      carry_flag_r <= carry_nxt;
  end

  // Nothing in this subset sets the expiry flag; power-down only clears it
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pd_flag_r       <= FLAGS_RST.power_down;
      wdog_exp_flag_r <= FLAGS_RST.wdog_expired;
    end
    else if (state_r == MX_EXEC && cur_r.op == MX_POWER_DOWN)
    begin
      pd_flag_r       <= 1'b1;
      wdog_exp_flag_r <= 1'b0;
    end
  end

  // No op of this subset touches overflow or half carry, so they keep their reset value
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      kept_flags_r <= {FLAGS_RST.signed_excess, FLAGS_RST.aux_carry};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      pc_r <= PC_RST;
    else if (state_r == MX_EXEC)
    begin
      if (cur_r.op == MX_DIRECT_JUMP)
        pc_r <= cur_r.target;
      else
        pc_r <= pc_r + 12'h001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      done_r <= 1'b0;
    else
      done_r <= (state_r == MX_EXEC);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      wdog_clear_r <= 1'b0;
    else
      wdog_clear_r <= (state_r == MX_EXEC) && (cur_r.op == MX_POWER_DOWN);
  end

  // Level output: raised with the power-down result, dropped once wake is seen
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      halted_r <= 1'b0;
    else if (state_r == MX_EXEC)
      halted_r <= (cur_r.op == MX_POWER_DOWN);
    else
      halted_r <= (state_r == MX_HALT) && !wake_s2_r;
  end
endmodule

// ===== rtl/mx_pkg.sv
// Package for the instruction-subset execution datapath
// Contract
// - Invert memory byte into accumulator, memory kept, only zero flag updated.
// - In-place increment or decrement of memory byte, stored back, zero flag only.
// - Increment or decrement into accumulator, memory kept, zero flag only.
// - Power-down stops execution, PC plus one, state kept, watchdog and prescaler cleared; here only the wdog_clear_r pulse, no prescaler exists.
// - Power-down sets power-down flag, clears watchdog expired flag, arithmetic flags kept.
// - Direct jump loads PC with instruction address, no flag changes.
// - Memory to accumulator copy, memory and flags unchanged.
// - Accumulator to memory copy, flags unchanged.
// - Bitwise union with memory or immediate, to accumulator or memory, zero flag only.
package mx_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W   = 12;
  localparam int ADDR_W = 8;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST  = 12'h000;
  localparam logic [3:0]        BCD_MAX = 4'h9;
  localparam logic [3:0]        BCD_ADJ = 4'h6;

  typedef enum logic [3:0] {
    MX_IDLE_STEP   = 4'h0,
    MX_INVERT_ACC  = 4'h1,
    MX_BCD_CORR    = 4'h2,
    MX_ADD_ONE_MEM = 4'h3,
    MX_SUB_ONE_MEM = 4'h4,
    MX_ADD_ONE_ACC = 4'h5,
    MX_SUB_ONE_ACC = 4'h6,
    MX_POWER_DOWN  = 4'h7,
    MX_DIRECT_JUMP = 4'h8,
    MX_COPY_M2A    = 4'h9,
    MX_COPY_A2M    = 4'ha,
    MX_COPY_IMM    = 4'hb,
    MX_UNION_MEM   = 4'hc,
    MX_UNION_IMM   = 4'hd,
    MX_UNION_TOMEM = 4'he
  } mx_op_type;

  typedef struct packed {
    mx_op_type         op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] imm;
    logic [PC_W-1:0]   target;
  } mx_instr_type;

  typedef struct packed {
    logic wdog_expired;
    logic power_down;
    logic signed_excess;
    logic zero;
    logic aux_carry;
    logic carry;
  } mx_flags_type;

  localparam mx_flags_type FLAGS_RST = '0;

  typedef enum logic [1:0] {
    MX_RUN   = 2'b00,
    MX_MEMRD = 2'b01,
    MX_EXEC  = 2'b11,
    MX_HALT  = 2'b10
  } mx_state_type;
endpackage

// ===== rtl/mx_alu.sv
// Combinational result and flag unit for the instruction subset
`timescale 1ns/1ps
module mx_alu
  import mx_pkg::*;
(
  input  mx_op_type         op,
  input  logic [DATA_W-1:0] acc,
  input  logic [DATA_W-1:0] mem,
  input  logic [DATA_W-1:0] imm,
  input  logic              carry_in,
  output logic [DATA_W-1:0] result,
  output logic              zero,
  output logic              carry_out
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic       lo_carry;

  // Low nibble carry feeds the high nibble decision
  always_comb
  begin
    lo_carry = (acc[3:0] > BCD_MAX);
    lo_sum   = lo_carry ? ({1'b0, acc[3:0]} + {1'b0, BCD_ADJ}) : {1'b0, acc[3:0]};
    hi_sum   = {1'b0, acc[7:4]} + {4'h0, lo_carry | lo_sum[4]};
    if ((hi_sum > {1'b0, BCD_MAX}) || carry_in)
      hi_sum = hi_sum + {1'b0, BCD_ADJ};
  end

  always_comb
  begin
    result    = acc;
    carry_out = carry_in;
    case (op)
      MX_INVERT_ACC:  result = ~mem;
      MX_BCD_CORR:
      begin
        result    = {hi_sum[3:0], lo_sum[3:0]};
        carry_out = hi_sum[4] | carry_in | (hi_sum[3:0] < acc[7:4]);
      end
      MX_ADD_ONE_MEM, MX_ADD_ONE_ACC: result = mem + 8'h01;
      MX_SUB_ONE_MEM, MX_SUB_ONE_ACC: result = mem - 8'h01;
      MX_COPY_M2A:    result = mem;
      MX_COPY_A2M:    result = acc;
      MX_COPY_IMM:    result = imm;
      MX_UNION_MEM, MX_UNION_TOMEM: result = acc | mem;
      MX_UNION_IMM:   result = acc | imm;
      default:        result = acc;
    endcase
  end

  assign zero = (result == 8'h00);
endmodule

// ===== dv/mx_core_asserts.sv
// Concurrent checks on the execution datapath top ports
`timescale 1ns/1ps
module mx_core_asserts
  import mx_pkg::*;
(
  input logic              mclk,
  input logic              rst_b,
  input logic              instr_valid,
  input mx_instr_type      instr,
  input logic              instr_ready,
  input logic [DATA_W-1:0] acc_r,
  input mx_flags_type      flags_r,
  input logic [PC_W-1:0]   pc_r,
  input logic              halted_r,
  input logic              wdog_clear_r,
  input logic              done_r
);
  mx_instr_type      in_q;
  logic [DATA_W-1:0] acc_q;
  mx_flags_type      fl_q;
  logic [PC_W-1:0]   pc_q;
  // State before the taken instruction, to judge what it changed
  always_ff @(posedge mclk)
    if (instr_valid && instr_ready)
    begin
      in_q  <= instr;
      acc_q <= acc_r;
      fl_q  <= flags_r;
      pc_q  <= pc_r;
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_jump_target: assert property (done_r && in_q.op == MX_DIRECT_JUMP |->
    pc_r == in_q.target && flags_r == fl_q)
    else $error("jump target wrong");
  chk_pc_advance: assert property (done_r && in_q.op != MX_DIRECT_JUMP |-> pc_r == pc_q + 12'h001)
    else $error("pc not advanced");
  chk_imm_load: assert property (done_r && in_q.op == MX_COPY_IMM |->
    acc_r == in_q.imm && flags_r == fl_q)
    else $error("immediate load wrong");
  chk_union_imm: assert property (done_r && in_q.op == MX_UNION_IMM |->
    acc_r == (acc_q | in_q.imm) && flags_r.zero == (acc_r == 8'h00))
    else $error("union result wrong");
  chk_pd_flags: assert property ($rose(halted_r) |->
    flags_r.power_down && !flags_r.wdog_expired && flags_r[3:0] == fl_q[3:0])
    else $error("power-down flags wrong");
  chk_pd_clear: assert property ($rose(halted_r) |-> wdog_clear_r && done_r && in_q.op == MX_POWER_DOWN)
    else $error("watchdog not cleared");
  chk_halt_stall: assert property (halted_r && $past(halted_r) |-> !instr_ready && $stable(pc_r))
    else $error("runs while halted");
  chk_move_flags: assert property (
    done_r && in_q.op inside {MX_COPY_M2A, MX_COPY_A2M, MX_IDLE_STEP} |->
    flags_r == fl_q && (in_q.op == MX_COPY_M2A || acc_r == acc_q))
    else $error("move changed state");
  chk_mem_ops: assert property (
    done_r && in_q.op inside {MX_ADD_ONE_MEM, MX_SUB_ONE_MEM, MX_UNION_TOMEM} |->
    acc_r == acc_q && {flags_r[5:3], flags_r[1:0]} == {fl_q[5:3], fl_q[1:0]})
    else $error("memory op side effect");
  chk_bcd_flags: assert property (done_r && in_q.op == MX_BCD_CORR |->
    acc_r == acc_q && flags_r[5:1] == fl_q[5:1] && (flags_r.carry || !fl_q.carry))
    else $error("bcd side effect");
endmodule
bind mx_core mx_core_asserts chk_u (.mclk, .rst_b, .instr_valid, .instr, .instr_ready, .acc_r, .flags_r,
  .pc_r, .halted_r, .wdog_clear_r, .done_r);

// ===== dv/testbench.sv
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
module testbench
  import mx_pkg::*;
;
  logic              mclk = 0, rst_b = 0, instr_valid = 0, wake = 0;
  mx_instr_type      instr = '0;
  logic              instr_ready, halted_r, wdog_clear_r, done_r;
  logic [DATA_W-1:0] acc_r, acc_m = ACC_RST, a, v, mem_m [0:255];
  mx_flags_type      flags_r, fl_m = FLAGS_RST;
  logic [PC_W-1:0]   pc_r, pc_m = PC_RST;
  logic [25:0]       exp_q [$];
  int                fails = 0, compares = 0;
  always #20 mclk = ~mclk;
  mx_core #(.MEM_DEPTH(160)) dut_u (.mclk, .rst_b, .instr_valid, .instr, .wake, .instr_ready, .acc_r,
    .flags_r, .pc_r, .halted_r, .wdog_clear_r, .done_r);
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run(input mx_op_type op, input logic [7:0] ad, x, input logic [11:0] t);
    logic [4:0] lo, hi;
    @(negedge mclk);
    instr_valid = 1;
    instr = '{op, ad, x, t};
    for (int i = 0; i < 40 && instr_ready !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    instr_valid = 0;
    case (op)
      MX_INVERT_ACC: acc_m = ~mem_m[ad];
      MX_ADD_ONE_MEM: mem_m[ad] = mem_m[ad] + 8'h01;
      MX_SUB_ONE_MEM: mem_m[ad] = mem_m[ad] - 8'h01;
      MX_ADD_ONE_ACC: acc_m = mem_m[ad] + 8'h01;
      MX_SUB_ONE_ACC: acc_m = mem_m[ad] - 8'h01;
      MX_COPY_M2A: acc_m = mem_m[ad];
      MX_COPY_A2M: mem_m[ad] = acc_m;
      MX_COPY_IMM: acc_m = x;
      MX_UNION_MEM: acc_m = acc_m | mem_m[ad];
      MX_UNION_IMM: acc_m = acc_m | x;
      MX_UNION_TOMEM: mem_m[ad] = mem_m[ad] | acc_m;
      MX_POWER_DOWN: fl_m = '{1'b0, 1'b1, fl_m[3], fl_m[2], fl_m[1], fl_m[0]};
      MX_BCD_CORR:
      begin
        lo = acc_m[3:0] + (acc_m[3:0] > BCD_MAX ? BCD_ADJ : 4'h0);
        hi = acc_m[7:4] + lo[4];
        if (hi > 5'h09 || fl_m.carry) hi = hi + 5'h06;
        fl_m.carry = fl_m.carry | hi[4];
        mem_m[ad] = {hi[3:0], lo[3:0]};
      end
      default: ;
    endcase
    // Out-of-range locations ignore writes and read back zero
    if (ad >= 8'ha0) mem_m[ad] = 8'h00;
    if (op inside {MX_INVERT_ACC, MX_ADD_ONE_ACC, MX_SUB_ONE_ACC, MX_UNION_MEM, MX_UNION_IMM})
      fl_m.zero = (acc_m == 8'h00);
    if (op inside {MX_ADD_ONE_MEM, MX_SUB_ONE_MEM, MX_UNION_TOMEM}) fl_m.zero = (mem_m[ad] == 8'h00);
    pc_m = (op == MX_DIRECT_JUMP) ? t : pc_m + 12'h001;
    exp_q.push_back({acc_m, fl_m, pc_m});
  endtask
  always @(negedge mclk)
    if (done_r === 1'b1)
      chk({acc_r, flags_r, pc_r}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  initial
  begin
    #200000;
    fails++;
    test_done();
  end
  initial
  begin
    void'($urandom(38));
    for (int i = 160; i < 256; i++) mem_m[i] = 8'h00;
    repeat (12) @(negedge mclk);
    rst_b = 1;
    run(MX_UNION_IMM, 8'h00, 8'h00, 12'h000);
    run(MX_COPY_IMM, 8'h00, 8'h5a, 12'h000);
    run(MX_DIRECT_JUMP, 8'h00, 8'h00, 12'hfff);
    run(MX_IDLE_STEP, 8'h00, 8'h00, 12'h000);
    $display("moves and jumps done");
    for (int i = 0; i < 6; i++)
    begin
      a = 8'($urandom_range(159, 0));
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      run(MX_COPY_IMM, a, v, 12'h000);
      run(MX_COPY_A2M, a, v, 12'h000);
      for (int k = 1; k < 15; k++)
        if (k != 7 && k != 8)
          run(mx_op_type'(k), a, v, 12'h000);
      run(MX_COPY_M2A, a, v, 12'h000);
    end
    run(MX_COPY_A2M, 8'hf0, 8'h00, 12'h000);
    run(MX_COPY_M2A, 8'hf0, 8'h00, 12'h000);
    $display("data ops done");
    run(MX_POWER_DOWN, 8'h00, 8'h00, 12'h000);
    repeat (8) @(negedge mclk);
    chk({halted_r, instr_ready}, 26'h2);
    wake = 1;
    for (int i = 0; i < 20 && halted_r !== 1'b0; i++) @(negedge mclk);
    wake = 0;
    run(MX_COPY_M2A, a, 8'h00, 12'h000);
    repeat (8) @(negedge mclk);
    chk(26'(exp_q.size()), 26'h0);
    $display("power-down done");
    test_done();
  end
endmodule
